// [core/scdpm_defs.svh]
// Constants for the serial controller data pin mux
//
// Notes on behaviour
// - Cell mode drives each transmit octet on eight lines, line seven the MSB.
// - With no payload cell ready, transmit sends idle cells so the stream never stops.
// - Every cell, payload or idle, is exactly 53 octets; both counters frame on that.
// - Cell mode samples each receive octet from eight lines, line seven the MSB.
// - In cell mode, receive lines are driven only while the receive enable strobe is asserted.
// - Nibble modes transmit four bits on four lines, line three the MSB.
// - Nibble modes receive four bits from four lines, line three the MSB.
// - Serial and transparent modes transmit one bit on a single line.
// - Serial and transparent modes receive one bit from a single line.
// - Pin twenty carries cell bit 5, or nibble bit 2.
// - Pin nineteen carries cell bit 6, or nibble bit 1.
// - Pin eighteen carries cell bit 7, nibble bit 0, or the serial bit.
// - Pin seventeen inputs cell bit 7, nibble bit 0, or the serial bit.
`ifndef SCDPM_DEFS_SVH
`define SCDPM_DEFS_SVH

// ----------------------------------------
// Cell framing
// ----------------------------------------
`define SCDPM_CELL_LAST 6'h34
`define SCDPM_CNT_RESET 6'h00
`define SCDPM_IDLE_HDR_LAST 6'h03
`define SCDPM_IDLE_HEC_POS 6'h04
`define SCDPM_IDLE_HDR_TAIL 8'h01
`define SCDPM_IDLE_HEC 8'h52
`define SCDPM_IDLE_FILL 8'h6A

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCDPM_OCTET_RESET 8'h00
`define SCDPM_PIN_RESET 4'h0
`define SCDPM_OEN_RESET 4'hF
`define SCDPM_SYNC_DEPTH 2

`endif

// [core/scdpm_pin_mux.sv]
// Data pin mux for the first fast serial controller
`timescale 1ns/1ns
`default_nettype none
`include "scdpm_defs.svh"
module scdpm_pin_mux (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire scdpm_pkg::scdpm_mode_e mode,
  input wire scdpm_pkg::scdpm_tx_s tx,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioDrive,
  input wire logic portAPinTwentyIn,
  output logic portAPinTwentyOut,
  output logic portAPinTwentyOeN,
  input wire logic portAPinNineteenIn,
  output logic portAPinNineteenOut,
  output logic portAPinNineteenOeN,
  input wire logic portAPinEighteenIn,
  output logic portAPinEighteenOut,
  output logic portAPinEighteenOeN,
  input wire logic portAPinSeventeenIn,
  output logic portAPinSeventeenOut,
  output logic portAPinSeventeenOeN,
  output logic [4:0] txLowLines,
  input wire logic [6:0] rxLowLines,
  output logic rx_enable_strobe_n,
  output logic payTake,
  output scdpm_pkg::scdpm_rx_s rx,
  output logic [3:0] gpioIn
);

  // ----------------------------------------
  // Line mapping
  // ----------------------------------------
  // Nibble bit j shares line 7-j with the cell octet, so bit 0 lands on line seven
  function automatic logic [7:0] linesFromNibble(input logic [3:0] nib);
    linesFromNibble = {nib[0], nib[1], nib[2], nib[3], 4'h0};
  endfunction : linesFromNibble

  function automatic logic [3:0] nibbleFromLines(input logic [7:0] lines);
    nibbleFromLines = {lines[4], lines[5], lines[6], lines[7]};
  endfunction : nibbleFromLines

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [10:0] pinSync;
  logic [7:0] rxLines;

  scdpm_sync #(.WIDTH(11)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({portAPinTwentyIn, portAPinNineteenIn, portAPinEighteenIn, portAPinSeventeenIn, rxLowLines}),
    .sync_out(pinSync)
  );

  assign rxLines = pinSync[7:0];

  // ----------------------------------------
  // Transmit cell framer
  // ----------------------------------------
  scdpm_pkg::scdpm_cell_e txState_r;
  scdpm_pkg::scdpm_cell_e txState_nxt;
  logic [5:0] txCnt_r;
  logic [5:0] txCnt_nxt;
  logic [7:0] txLines_r;
  logic [7:0] txLines_nxt;
  logic payTake_r;
  logic payTake_nxt;
  logic [7:0] idleOctet;

  always_comb begin
    if (txCnt_r <= `SCDPM_IDLE_HDR_LAST) begin
      idleOctet = (txCnt_r == `SCDPM_IDLE_HDR_LAST) ? `SCDPM_IDLE_HDR_TAIL : `SCDPM_OCTET_RESET;
    end else if (txCnt_r == `SCDPM_IDLE_HEC_POS) begin
      idleOctet = `SCDPM_IDLE_HEC;
    end else begin
      idleOctet = `SCDPM_IDLE_FILL;
    end
  end

  always_comb begin
    txState_nxt = txState_r;
    txCnt_nxt = txCnt_r;
    txLines_nxt = `SCDPM_OCTET_RESET;
    case (mode)
      scdpm_pkg::MODE_CELL: begin
        // Decide payload or idle only on a cell boundary, so cells never tear
        if (txState_r == scdpm_pkg::CELL_OFF || txCnt_r == `SCDPM_CELL_LAST) begin
          txState_nxt = tx.payCellReady ? scdpm_pkg::CELL_PAYLOAD : scdpm_pkg::CELL_IDLE;
        end
        if (txState_r == scdpm_pkg::CELL_OFF || txCnt_r == `SCDPM_CELL_LAST) begin
          txCnt_nxt = `SCDPM_CNT_RESET;
        end else begin
          txCnt_nxt = txCnt_r + 6'h01;
        end
        case (txState_r)
          scdpm_pkg::CELL_PAYLOAD: txLines_nxt = tx.payData;
          scdpm_pkg::CELL_IDLE: txLines_nxt = idleOctet;
          default: txLines_nxt = `SCDPM_OCTET_RESET;
        endcase
      end
      scdpm_pkg::MODE_NIBBLE: begin
        txState_nxt = scdpm_pkg::CELL_OFF;
        txCnt_nxt = `SCDPM_CNT_RESET;
        txLines_nxt = linesFromNibble(tx.nibble);
      end
      scdpm_pkg::MODE_SERIAL: begin
        txState_nxt = scdpm_pkg::CELL_OFF;
        txCnt_nxt = `SCDPM_CNT_RESET;
        txLines_nxt = {tx.serBit, 7'h00};
      end
      default: begin
        txState_nxt = scdpm_pkg::CELL_OFF;
        txCnt_nxt = `SCDPM_CNT_RESET;
      end
    endcase
    // High in the cycle whose closing edge loads a payload octet; source must refresh every such cycle
    payTake_nxt = (mode == scdpm_pkg::MODE_CELL) && (txState_nxt == scdpm_pkg::CELL_PAYLOAD);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_r <= scdpm_pkg::CELL_OFF;
      txCnt_r <= `SCDPM_CNT_RESET;
      txLines_r <= `SCDPM_OCTET_RESET;
      payTake_r <= 1'b0;
    end else begin
      txState_r <= txState_nxt;
      txCnt_r <= txCnt_nxt;
      txLines_r <= txLines_nxt;
      payTake_r <= payTake_nxt;
    end
  end

  // ----------------------------------------
  // Pin ownership
  // ----------------------------------------
  logic [3:0] pinOut_r;
  logic [3:0] pinOut_nxt;
  logic [3:0] pinOeN_r;
  logic [3:0] pinOeN_nxt;
  logic [4:0] txLow_r;
  logic [4:0] txLow_nxt;

  // Index 3..0 are pins twenty, nineteen, eighteen, seventeen
  always_comb begin
    pinOut_nxt = gpioOut;
    pinOeN_nxt = ~gpioDrive;
    txLow_nxt = 5'h00;
    case (mode)
      scdpm_pkg::MODE_CELL, scdpm_pkg::MODE_NIBBLE: begin
        pinOut_nxt = {txLines_nxt[5], txLines_nxt[6], txLines_nxt[7], 1'b0};
        pinOeN_nxt = 4'h1;
        txLow_nxt = txLines_nxt[4:0];
      end
      scdpm_pkg::MODE_SERIAL: begin
        // Pins twenty and nineteen are unused here and stay general purpose
        pinOut_nxt = {gpioOut[3:2], txLines_nxt[7], 1'b0};
        pinOeN_nxt = {~gpioDrive[3:2], 2'h1};
      end
      default: begin
        pinOut_nxt = gpioOut;
        pinOeN_nxt = ~gpioDrive;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_r <= `SCDPM_PIN_RESET;
      pinOeN_r <= `SCDPM_OEN_RESET;
      txLow_r <= 5'h00;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOeN_r <= pinOeN_nxt;
      txLow_r <= txLow_nxt;
    end
  end

  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  logic strobeN_r;
  logic strobeN_nxt;
  logic [1:0] strobeDly_r;
  logic [1:0] strobeDly_nxt;
  logic [5:0] rxCnt_r;
  logic [5:0] rxCnt_nxt;
  scdpm_pkg::scdpm_rx_s rx_r;
  scdpm_pkg::scdpm_rx_s rx_nxt;
  logic [3:0] gpioIn_r;
  logic [3:0] gpioIn_nxt;

  always_comb begin
    // Single PHY: strobe held while in cell mode
    strobeN_nxt = (mode != scdpm_pkg::MODE_CELL);
    // Delay matches the synchroniser so data and strobe line up
    strobeDly_nxt = {strobeDly_r[0], ~strobeN_r};
    rxCnt_nxt = rxCnt_r;
    rx_nxt = '0;
    rx_nxt.octet = rx_r.octet;
    rx_nxt.nibble = rx_r.nibble;
    rx_nxt.serBit = rx_r.serBit;
    gpioIn_nxt = pinSync[10:7];
    if (mode == scdpm_pkg::MODE_CELL && strobeDly_r[1]) begin
      rx_nxt.octet = rxLines;
      rx_nxt.octetValid = 1'b1;
      rx_nxt.cellStart = (rxCnt_r == `SCDPM_CNT_RESET);
      rxCnt_nxt = (rxCnt_r == `SCDPM_CELL_LAST) ? `SCDPM_CNT_RESET : rxCnt_r + 6'h01;
    end else if (mode != scdpm_pkg::MODE_CELL) begin
      rxCnt_nxt = `SCDPM_CNT_RESET;
    end
    if (mode == scdpm_pkg::MODE_NIBBLE) begin
      rx_nxt.nibble = nibbleFromLines(rxLines);
      rx_nxt.nibbleValid = 1'b1;
    end
    if (mode == scdpm_pkg::MODE_SERIAL) begin
      rx_nxt.serBit = rxLines[7];
      rx_nxt.serValid = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobeN_r <= 1'b1;
      strobeDly_r <= 2'h0;
      rxCnt_r <= `SCDPM_CNT_RESET;
      rx_r <= '0;
      gpioIn_r <= `SCDPM_PIN_RESET;
    end else begin
      strobeN_r <= strobeN_nxt;
      strobeDly_r <= strobeDly_nxt;
      rxCnt_r <= rxCnt_nxt;
      rx_r <= rx_nxt;
      gpioIn_r <= gpioIn_nxt;
    end
  end

  assign portAPinTwentyOut = pinOut_r[3];
  assign portAPinNineteenOut = pinOut_r[2];
  assign portAPinEighteenOut = pinOut_r[1];
  assign portAPinSeventeenOut = pinOut_r[0];
  assign portAPinTwentyOeN = pinOeN_r[3];
  assign portAPinNineteenOeN = pinOeN_r[2];
  assign portAPinEighteenOeN = pinOeN_r[1];
  assign portAPinSeventeenOeN = pinOeN_r[0];
  assign txLowLines = txLow_r;
  assign rx_enable_strobe_n = strobeN_r;
  assign payTake = payTake_r;
  assign rx = rx_r;
  assign gpioIn = gpioIn_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  cell_count_bound_a: assert property (txCnt_r <= `SCDPM_CELL_LAST && rxCnt_r <= `SCDPM_CELL_LAST)
    else $error("octet counter beyond cell length");
  cell_count_wrap_a: assert property (
    (mode == scdpm_pkg::MODE_CELL && txCnt_r == `SCDPM_CELL_LAST) |=> txCnt_r == 6'h00)
    else $error("cell did not end after 53 octets");
  idle_insert_a: assert property (
    (mode == scdpm_pkg::MODE_CELL && txCnt_r == `SCDPM_CELL_LAST && !tx.payCellReady)
      |=> txState_r == scdpm_pkg::CELL_IDLE)
    else $error("idle cell not inserted");
  cell_octet_pins_a: assert property (
    (mode == scdpm_pkg::MODE_CELL && txState_r == scdpm_pkg::CELL_PAYLOAD)
      |=> portAPinEighteenOut == $past(tx.payData[7]) && portAPinNineteenOut == $past(tx.payData[6])
        && portAPinTwentyOut == $past(tx.payData[5]) && txLowLines == $past(tx.payData[4:0]))
    else $error("cell octet not on transmit lines");
  nibble_pins_a: assert property ((mode == scdpm_pkg::MODE_NIBBLE)
      |=> portAPinTwentyOut == $past(tx.nibble[2]) && portAPinNineteenOut == $past(tx.nibble[1])
        && portAPinEighteenOut == $past(tx.nibble[0]) && txLowLines[4] == $past(tx.nibble[3]))
    else $error("nibble mapping wrong");
  serial_pin_a: assert property ((mode == scdpm_pkg::MODE_SERIAL)
      |=> portAPinEighteenOut == $past(tx.serBit) && !portAPinEighteenOeN)
    else $error("serial bit not on pin eighteen");
  pin17_input_a: assert property ((mode != scdpm_pkg::MODE_GPIO) |=> portAPinSeventeenOeN)
    else $error("pin seventeen driven in controller mode");
  rx_strobe_gate_a: assert property (rx.octetValid |-> $past(rx_enable_strobe_n, 3) == 1'b0)
    else $error("receive octet taken without strobe");
  rx_nibble_a: assert property ((mode == scdpm_pkg::MODE_NIBBLE) [*3]
      |=> rx.nibble[0] == $past(portAPinSeventeenIn, 3))
    else $error("receive nibble bit 0 not from pin seventeen");
  rx_serial_a: assert property ((mode == scdpm_pkg::MODE_SERIAL) [*3]
      |=> rx.serBit == $past(portAPinSeventeenIn, 3))
    else $error("serial receive bit not from pin seventeen");

  payload_cell_c: cover property (txState_r == scdpm_pkg::CELL_PAYLOAD && txCnt_r == `SCDPM_CELL_LAST);
  idle_cell_c: cover property (txState_r == scdpm_pkg::CELL_IDLE && txCnt_r == `SCDPM_CELL_LAST);
  rx_cell_c: cover property (rx.cellStart);

endmodule : scdpm_pin_mux
`default_nettype wire

// [core/scdpm_pkg.sv]
// Types shared by the serial controller data pin mux
package scdpm_pkg;

  typedef enum logic [1:0] {
    MODE_GPIO,
    MODE_CELL,
    MODE_NIBBLE,
    MODE_SERIAL
  } scdpm_mode_e;

  typedef enum logic [1:0] {
    CELL_OFF,
    CELL_IDLE,
    CELL_PAYLOAD
  } scdpm_cell_e;

  typedef struct packed {
    logic [7:0] payData;
    logic payCellReady;
    logic [3:0] nibble;
    logic serBit;
  } scdpm_tx_s;

  typedef struct packed {
    logic [7:0] octet;
    logic octetValid;
    logic cellStart;
    logic [3:0] nibble;
    logic nibbleValid;
    logic serBit;
    logic serValid;
  } scdpm_rx_s;

endpackage : scdpm_pkg

// [core/scdpm_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module scdpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] hold_r;
  logic [WIDTH-1:0] hold_nxt;

  always_comb begin
    meta_nxt = async_in;
    hold_nxt = meta_r;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign sync_out = hold_r;

endmodule : scdpm_sync
`default_nettype wire

// [sim/scdpm_phy_model.sv]
// External PHY model driving the receive data lines
`timescale 1ns/1ns
`default_nettype none
module scdpm_phy_model (
  input wire logic core_clk,
  input wire logic drive,
  input wire logic [7:0] sendVal,
  output logic [7:0] lines
);
  logic [7:0] last_r;

  // No pull on these lines, so a released line shows the inverse of its last level
  assign lines = drive ? sendVal : ~last_r;

  always_ff @(posedge core_clk) begin
    last_r <= lines;
  end
endmodule : scdpm_phy_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the serial controller data pin mux
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  scdpm_pkg::scdpm_mode_e mode;
  scdpm_pkg::scdpm_tx_s tx;
  scdpm_pkg::scdpm_rx_s rx;
  logic [3:0] gpioOut, gpioDrive, gpioIn, nib;
  logic ready, ser, mon, rx_enable_strobe_n, payTake, phyDrive;
  logic o20, o19, o18, o17, e20, e19, e18, e17, in20, in19, in18, in17;
  logic [4:0] txLowLines;
  logic [7:0] phy, rowVal, rxCnt, sendVal;
  logic [7:0] hist [4];
  logic [5:0] payIdx;
  logic [1:0] cyc;
  scdpm_pkg::scdpm_mode_e prevMode;
  int numErrors = 0;
  int cmpCount = 0;
  int rxN = 0;
  logic [22:0] rows [6];

  always #5 core_clk = ~core_clk;

  // Pins 20..18 idle at 1,0,1 when nobody drives them
  assign in20 = e20 ? 1'b1 : o20;
  assign in19 = e19 ? 1'b0 : o19;
  assign in18 = e18 ? 1'b1 : o18;
  assign in17 = e17 ? phy[7] : o17;
  assign tx = {8'h80 + {2'h0, payIdx}, ready, nib, ser};
  assign phyDrive = !rx_enable_strobe_n || mode == scdpm_pkg::MODE_NIBBLE || mode == scdpm_pkg::MODE_SERIAL;
  assign sendVal = (mode == scdpm_pkg::MODE_CELL) ? rxCnt : rowVal;

  scdpm_pin_mux scdpm_pin_mux_i (
    .core_clk, .reset_n, .mode, .tx, .gpioOut, .gpioDrive,
    .portAPinTwentyIn(in20), .portAPinTwentyOut(o20), .portAPinTwentyOeN(e20),
    .portAPinNineteenIn(in19), .portAPinNineteenOut(o19), .portAPinNineteenOeN(e19),
    .portAPinEighteenIn(in18), .portAPinEighteenOut(o18), .portAPinEighteenOeN(e18),
    .portAPinSeventeenIn(in17), .portAPinSeventeenOut(o17), .portAPinSeventeenOeN(e17),
    .txLowLines, .rxLowLines(phy[6:0]), .rx_enable_strobe_n, .payTake, .rx, .gpioIn
  );

  scdpm_phy_model scdpm_phy_model_i (.core_clk, .drive(phyDrive), .sendVal, .lines(phy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Far side stimulus and receive monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    payIdx <= (mode != scdpm_pkg::MODE_CELL) ? 6'h00 : payIdx + {5'h00, payTake};
    rxCnt <= rxCnt + 8'h01;
    cyc <= cyc + 2'h1;
    prevMode <= mode;
  end

  always @(negedge core_clk) begin
    if (mon) begin
      hist[cyc] = phy;
      chk(rx_enable_strobe_n, prevMode != scdpm_pkg::MODE_CELL);
      if (rx.octetValid) begin
        chk(rx.octet, hist[cyc + 2'h1]);
        chk(rx.cellStart, rxN % 53 == 0);
        rxN++;
      end else begin
        rxN = 0;
      end
    end
  end

  // Cell transmit: first cell payload, then idle cells once the source empties
  task automatic cell_run(input int nOct, input int dropAt);
    int p;
    logic [7:0] e;
    ready <= 1'b1;
    // Three cycles outside cell mode drain the receive strobe delay, so each run opens a fresh cell both ways
    mode <= scdpm_pkg::MODE_GPIO;
    repeat (3) @(posedge core_clk);
    mode <= scdpm_pkg::MODE_CELL;
    repeat (2) @(posedge core_clk);
    for (int n = 0; n < nOct; n++) begin
      @(negedge core_clk);
      p = n % 53;
      e = (n < 53) ? 8'h80 + 8'(p) : (p < 3) ? 8'h00 : (p == 3) ? 8'h01 : (p == 4) ? 8'h52 : 8'h6A;
      chk({e20, e19, e18, o18, o19, o20, txLowLines}, {3'b000, e});
      if (n < nOct - 1) begin
        chk(payTake, n + 1 < 53);
      end
      @(posedge core_clk);
      if (n == dropAt) begin
        ready <= 1'b0;
      end
    end
  endtask : cell_run

  initial begin
    #20000;
    numErrors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [22:0] r;
    logic [7:0] v;
    mode = scdpm_pkg::MODE_GPIO;
    {ready, ser, nib, gpioOut, gpioDrive, rowVal, payIdx, rxCnt, cyc, mon} = '0;
    // mode, nibble, serial bit, gpio value, gpio drive, expected enables, expected pins (20..17)
    rows = '{{2'h2, 4'hA, 1'h0, 4'h0, 4'h0, 4'h1, 4'h4}, {2'h2, 4'h5, 1'h0, 4'h0, 4'h0, 4'h1, 4'hA},
             {2'h3, 4'h0, 1'h1, 4'hA, 4'hF, 4'h1, 4'hA}, {2'h3, 4'h0, 1'h0, 4'h4, 4'h4, 4'h9, 4'h4},
             {2'h0, 4'h0, 1'h0, 4'h9, 4'hF, 4'h0, 4'h9}, {2'h0, 4'h0, 1'h0, 4'h0, 4'h0, 4'hF, 4'h0}};
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({o20, o19, o18, o17, e20, e19, e18, e17, rx_enable_strobe_n, payTake, txLowLines}, 15'h07C0);
    chk({rx, gpioIn}, '0);
    @(posedge core_clk);
    reset_n <= 1'b1;
    mon <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      v = 8'h96 + 8'(i * 37);
      @(posedge core_clk);
      mode <= scdpm_pkg::scdpm_mode_e'(r[22:21]);
      {nib, ser, gpioOut, gpioDrive} <= r[20:8];
      rowVal <= v;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk({e20, e19, e18, e17}, r[7:4]);
      chk({o20, o19, o18, o17} & ~r[7:4], r[3:0] & ~r[7:4]);
      chk(gpioIn[3:1], (r[3:1] & ~r[7:5]) | (3'b101 & r[7:5]));
      if (r[22:21] != 2'h0 || !r[4]) begin
        chk(gpioIn[0], (r[22:21] != 2'h0) ? v[7] : r[0]);
      end
      if (r[22:21] == 2'h2) begin
        chk({txLowLines[4], rx.nibble, rx.nibbleValid}, {r[20], v[4], v[5], v[6], v[7], 1'b1});
      end
      if (r[22:21] == 2'h3) begin
        chk({rx.serBit, rx.serValid}, {v[7], 1'b1});
      end
    end
    @(posedge core_clk);
    cell_run(159, 20);
    cell_run(30, 999);
    mode <= scdpm_pkg::MODE_NIBBLE;
    repeat (4) @(posedge core_clk);
    cell_run(53, 999);
    cell_run(10, 999);
    #2;
    mon = 1'b0;
    reset_n = 1'b0;
    #1;
    chk({e20, e19, e18, e17, rx_enable_strobe_n, payTake, rx.octetValid}, 7'h7C);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
